// ==== logic/pvc_consts.vh ====
// register map, field positions, reset values and timing counts for the calibration control
`ifndef PVC_CONSTS_VH
`define PVC_CONSTS_VH
`define PVC_ADDR_TRIM 8'h59
`define PVC_ADDR_PLL_RST 8'h5c
`define PVC_ADDR_TUNE_CTRL 8'h5d
`define PVC_ADDR_TUNE_STATE 8'h5e
`define PVC_ADDR_RUN_CTRL 8'h61
`define PVC_ADDR_MODE_SEL 8'h62
`define PVC_RST_TRIM 8'h00
`define PVC_RST_PLL_RST 8'h00
`define PVC_RST_TUNE_CTRL 8'h40
`define PVC_RST_RUN_CTRL 8'h01
`define PVC_RST_MODE_SEL 8'h01
`define PVC_TUNE_EN_BIT 0
`define PVC_SETTLE_HI 6
`define PVC_SETTLE_LO 4
`define PVC_PLL_RST_BIT 0
`define PVC_RUN_BIT 0
`define PVC_FG_BIT 0
`define PVC_BG_BIT 1
`define PVC_FGOS_BIT 2
`define PVC_BGOS_BIT 3
`define PVC_TUNE_CTRL_MASK 8'h71
`define PVC_MODE_SEL_MASK 8'h0f
`define PVC_TRIM_MASK 8'h7f
// settle base 40 ns and foreground run 500 ns at the 5 ns clock
`define PVC_SETTLE_BASE_CYC 12'h008
`define PVC_FG_CAL_CYC 10'h064
`define PVC_TRIM_MID 7'h40
`endif

// ==== logic/pvc_settle_timer.v ====
// settle wait counter: length scales with the settle select
`timescale 1ns/1ps
`include "pvc_consts.vh"
module pvc_settle_timer (
  input wire sys_clk,
  input wire sys_rst,
  input wire start,
  input wire [2:0] settle_sel,
  output reg done
);
  reg [11:0] count_r;
  reg busy_r;
  wire [11:0] base_cyc;
  wire [11:0] length;
  assign base_cyc = `PVC_SETTLE_BASE_CYC;
  // wait = base << (select + 1), larger select longer wait
  assign length = base_cyc << ({1'b0, settle_sel} + 4'h1);
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count_r <= 12'h000;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_r <= length - 12'h001;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (count_r == 12'h000) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end else begin
          count_r <= count_r - 12'h001;
        end
      end
    end
  end
endmodule // pvc_settle_timer

// ==== logic/pvc_cal_ctrl.v ====
// register bank and sequencing for oscillator tuning and converter calibration
`timescale 1ns/1ps
`include "pvc_consts.vh"
module pvc_cal_ctrl (
  input wire sys_clk,
  input wire sys_rst,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire freq_too_high,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg [6:0] oscillator_trim_code,
  output reg pll_hold_reset,
  output reg oscillator_tuning_complete,
  output reg cal_logic_reset,
  output reg div_reset,
  output reg cal_values_reset,
  output reg fg_cal_active,
  output reg bg_cal_active,
  output reg fg_offset_active,
  output reg bg_offset_active
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SETTLE = 3'h1;
  localparam ST_DECIDE = 3'h2;
  localparam ST_DONE = 3'h3;
  localparam ST_HELD = 3'h4;
  localparam FG_IDLE = 2'h0;
  localparam FG_CLEAR = 2'h1;
  localparam FG_RUN = 2'h2;
  localparam FG_FIN = 2'h3;

  reg [7:0] tune_ctrl_r;
  reg [7:0] run_ctrl_r;
  reg [7:0] mode_sel_r;
  reg [7:0] trim_r;
  reg pll_rst_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [6:0] step_r;
  reg [6:0] step_nxt;
  reg [6:0] trim_nxt;
  reg settle_start;
  reg complete_nxt;
  reg [1:0] fg_st_r;
  reg [9:0] fg_cnt_r;
  wire settle_done;
  wire tune_en;
  wire run_en;
  wire fg_sel;
  wire bg_sel;
  wire hold_release;
  wire sw_trim_wr;

  assign tune_en = tune_ctrl_r[`PVC_TUNE_EN_BIT];
  assign run_en = run_ctrl_r[`PVC_RUN_BIT];
  assign fg_sel = mode_sel_r[`PVC_FG_BIT];
  assign bg_sel = mode_sel_r[`PVC_BG_BIT];
  assign sw_trim_wr = wr_en && (addr == `PVC_ADDR_TRIM);
  // release of hold-reset by a write of zero
  assign hold_release = wr_en && (addr == `PVC_ADDR_PLL_RST) && pll_rst_r
    && !wr_data[`PVC_PLL_RST_BIT];

  pvc_settle_timer u_settle (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(settle_start),
    .settle_sel(tune_ctrl_r[`PVC_SETTLE_HI:`PVC_SETTLE_LO]),
    .done(settle_done)
  );

  // register writes
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      tune_ctrl_r <= `PVC_RST_TUNE_CTRL;
      run_ctrl_r <= `PVC_RST_RUN_CTRL;
      mode_sel_r <= `PVC_RST_MODE_SEL;
      pll_rst_r <= 1'b0;
    end else if (wr_en) begin
      if (addr == `PVC_ADDR_PLL_RST) begin
        pll_rst_r <= wr_data[`PVC_PLL_RST_BIT];
      end else if (addr == `PVC_ADDR_TUNE_CTRL) begin
        tune_ctrl_r <= wr_data & `PVC_TUNE_CTRL_MASK;
      end else if (addr == `PVC_ADDR_RUN_CTRL) begin
        run_ctrl_r <= {7'h00, wr_data[`PVC_RUN_BIT]};
      end else if (addr == `PVC_ADDR_MODE_SEL) begin
        mode_sel_r <= wr_data & `PVC_MODE_SEL_MASK;
      end
    end
  end

  // binary search of trim code, one bit per settled step
  always @* begin
    st_nxt = st_r;
    step_nxt = step_r;
    trim_nxt = trim_r[6:0];
    settle_start = 1'b0;
    complete_nxt = oscillator_tuning_complete;
    case (st_r)
      ST_IDLE: begin
        if (pll_rst_r) begin
          st_nxt = ST_HELD;
        end
      end
      ST_HELD: begin
        // flag low while held with tuning armed
        complete_nxt = !tune_en;
        if (hold_release) begin
          if (tune_en) begin
            st_nxt = ST_SETTLE;
            step_nxt = `PVC_TRIM_MID;
            trim_nxt = `PVC_TRIM_MID;
            settle_start = 1'b1;
            complete_nxt = 1'b0;
          end else begin
            st_nxt = ST_DONE;
            complete_nxt = 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          st_nxt = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (freq_too_high) begin
          trim_nxt = trim_r[6:0] & ~step_r;
        end
        if (step_r == 7'h01) begin
          st_nxt = ST_DONE;
          complete_nxt = 1'b1;
        end else begin
          step_nxt = {1'b0, step_r[6:1]};
          trim_nxt = (freq_too_high ? (trim_r[6:0] & ~step_r) : trim_r[6:0])
            | {1'b0, step_r[6:1]};
          settle_start = 1'b1;
          st_nxt = ST_SETTLE;
        end
      end
      ST_DONE: begin
        if (pll_rst_r) begin
          st_nxt = ST_HELD;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (pll_rst_r && (st_r == ST_SETTLE || st_r == ST_DECIDE)) begin
      st_nxt = ST_HELD;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      step_r <= 7'h00;
      trim_r <= `PVC_RST_TRIM;
      oscillator_tuning_complete <= 1'b0;
    end else begin
      st_r <= st_nxt;
      step_r <= step_nxt;
      oscillator_tuning_complete <= complete_nxt;
      // engine or software writes the trim code
      if (sw_trim_wr) begin
        trim_r <= wr_data & `PVC_TRIM_MASK;
      end else begin
        trim_r <= {1'b0, trim_nxt};
      end
    end
  end

  // foreground calibration sequence, restarted on every rising edge of the run bit
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fg_st_r <= FG_IDLE;
      fg_cnt_r <= 10'h000;
    end else if (!run_en) begin
      // held in reset while run bit low
      fg_st_r <= FG_IDLE;
      fg_cnt_r <= 10'h000;
    end else begin
      case (fg_st_r)
        FG_IDLE: begin
          fg_st_r <= FG_CLEAR;
        end
        FG_CLEAR: begin
          // values reset, foreground run only if selected
          if (fg_sel) begin
            fg_st_r <= FG_RUN;
            fg_cnt_r <= `PVC_FG_CAL_CYC - 10'h001;
          end else begin
            fg_st_r <= FG_FIN;
          end
        end
        FG_RUN: begin
          if (fg_cnt_r == 10'h000) begin
            fg_st_r <= FG_FIN;
          end else begin
            fg_cnt_r <= fg_cnt_r - 10'h001;
          end
        end
        default: begin
          fg_st_r <= FG_FIN;
        end
      endcase
    end
  end

  // outputs and read data
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      oscillator_trim_code <= 7'h00;
      pll_hold_reset <= 1'b0;
      cal_logic_reset <= 1'b0;
      div_reset <= 1'b0;
      cal_values_reset <= 1'b0;
      fg_cal_active <= 1'b0;
      bg_cal_active <= 1'b0;
      fg_offset_active <= 1'b0;
      bg_offset_active <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (addr == `PVC_ADDR_TRIM) begin
        rd_data <= trim_r;
      end else if (addr == `PVC_ADDR_PLL_RST) begin
        rd_data <= {7'h00, pll_rst_r};
      end else if (addr == `PVC_ADDR_TUNE_CTRL) begin
        rd_data <= tune_ctrl_r;
      end else if (addr == `PVC_ADDR_TUNE_STATE) begin
        rd_data <= {7'h00, oscillator_tuning_complete};
      end else if (addr == `PVC_ADDR_RUN_CTRL) begin
        rd_data <= run_ctrl_r;
      end else if (addr == `PVC_ADDR_MODE_SEL) begin
        rd_data <= mode_sel_r;
      end else begin
        rd_data <= 8'h00;
      end
      oscillator_trim_code <= trim_r[6:0];
      pll_hold_reset <= pll_rst_r;
      cal_logic_reset <= !run_en;
      div_reset <= !run_en;
      cal_values_reset <= (fg_st_r == FG_CLEAR);
      fg_cal_active <= (fg_st_r == FG_RUN);
      bg_cal_active <= run_en && bg_sel && (fg_st_r == FG_FIN);
      // foreground offset gated by foreground run
      fg_offset_active <= (fg_st_r == FG_RUN) && mode_sel_r[`PVC_FGOS_BIT];
      // background offset gated by background enable
      bg_offset_active <= run_en && bg_sel && (fg_st_r == FG_FIN)
        && mode_sel_r[`PVC_BGOS_BIT];
    end
  end
endmodule // pvc_cal_ctrl

// ==== verif/pvc_cal_checker.sv ====
// port-level assertions for the calibration control block
`timescale 1ns/1ps
module pvc_cal_checker (
  input wire sys_clk,
  input wire sys_rst,
  input wire rd_en,
  input wire rd_valid,
  input wire cal_logic_reset,
  input wire div_reset,
  input wire cal_values_reset,
  input wire fg_cal_active,
  input wire bg_cal_active,
  input wire fg_offset_active,
  input wire bg_offset_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rdv; rd_en |=> rd_valid; endproperty
  property p_rdq; !rd_en |=> !rd_valid; endproperty
  property p_div; cal_logic_reset == div_reset; endproperty
  property p_hold; cal_logic_reset |=> !fg_cal_active && !bg_cal_active; endproperty
  property p_fgos; fg_offset_active |-> fg_cal_active || $past(fg_cal_active); endproperty
  property p_bgos; bg_offset_active |-> bg_cal_active || $past(bg_cal_active); endproperty
  property p_excl; bg_cal_active |-> !fg_cal_active; endproperty
  property p_pulse; cal_values_reset |=> !cal_values_reset; endproperty
  a_rdv: assert property (p_rdv) else $error("read answer missing");
  a_rdq: assert property (p_rdq) else $error("read answer without request");
  a_div: assert property (p_div) else $error("divider hold differs from cal hold");
  a_hold: assert property (p_hold) else $error("calibration active while held");
  a_fgos: assert property (p_fgos) else $error("fg offset without fg cal");
  a_bgos: assert property (p_bgos) else $error("bg offset without bg cal");
  a_excl: assert property (p_excl) else $error("bg cal during fg phase");
  a_pulse: assert property (p_pulse) else $error("value reset longer than one cycle");
  c_fg: cover property ($rose(fg_cal_active));
  c_bg: cover property ($rose(bg_offset_active));
  c_hold: cover property ($rose(div_reset));
endmodule // pvc_cal_checker

bind pvc_cal_ctrl pvc_cal_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .rd_en(rd_en),
  .rd_valid(rd_valid), .cal_logic_reset(cal_logic_reset), .div_reset(div_reset),
  .cal_values_reset(cal_values_reset), .fg_cal_active(fg_cal_active),
  .bg_cal_active(bg_cal_active), .fg_offset_active(fg_offset_active),
  .bg_offset_active(bg_offset_active));

// ==== verif/pvc_cal_ctrl_test.sv ====
// self-checking bench for the calibration control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module pvc_cal_ctrl_test;
  reg sys_clk = 0, sys_rst = 1, wr_en = 0, rd_en = 0, freq_too_high = 0;
  reg [7:0] addr = 8'h00, wr_data = 8'h00, tgt = 8'h00, m, fg;
  reg pv, os;
  wire [7:0] rd_data;
  wire [6:0] oscillator_trim_code;
  wire rd_valid, pll_hold_reset, oscillator_tuning_complete, cal_logic_reset, div_reset;
  wire cal_values_reset, fg_cal_active, bg_cal_active, fg_offset_active, bg_offset_active;
  int failures = 0, check_count = 0, n0, n1;
  reg [7:0] tl [0:2] = '{8'h00, 8'h5a, 8'h7f};
  reg [7:0] ml [0:6] = '{8'h01, 8'h05, 8'h0f, 8'h02, 8'h00, 8'h08, 8'h0a};
  pvc_cal_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .freq_too_high(freq_too_high), .rd_data(rd_data),
    .rd_valid(rd_valid), .oscillator_trim_code(oscillator_trim_code),
    .pll_hold_reset(pll_hold_reset), .oscillator_tuning_complete(oscillator_tuning_complete),
    .cal_logic_reset(cal_logic_reset), .div_reset(div_reset),
    .cal_values_reset(cal_values_reset), .fg_cal_active(fg_cal_active),
    .bg_cal_active(bg_cal_active), .fg_offset_active(fg_offset_active),
    .bg_offset_active(bg_offset_active));
  always #2.5 sys_clk = ~sys_clk;
  // oscillator comparator against the target code
  always @(negedge sys_clk) freq_too_high <= {1'b0, oscillator_trim_code} > tgt;
  task conclude;
    begin
      if (failures == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    begin
      addr = a;
      wr_data = d;
      wr_en = 1;
      @(negedge sys_clk) wr_en = 0;
      @(negedge sys_clk);
    end
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    begin
      addr = a;
      rd_en = 1;
      @(negedge sys_clk) rd_en = 0;
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rd_data", e, rd_data)
      @(negedge sys_clk);
    end
  endtask
  // hold, program tuning control, release and count cycles to completion
  task automatic tune(input [7:0] ctl, output int n);
    begin
      wr(8'h5c, 8'h01);
      `CHK("hold_out", 1'b1, pll_hold_reset)
      wr(8'h5d, ctl);
      if (ctl[0]) rd(8'h5e, 8'h00);
      wr(8'h5c, 8'h00);
      n = 0;
      while (oscillator_tuning_complete !== 1'b1 && n < 3000) begin
        @(negedge sys_clk);
        n++;
      end
      if (n >= 3000) begin
        failures++;
        conclude();
      end
      `CHK("hold_out", 1'b0, pll_hold_reset)
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 0;
    rd(8'h5d, 8'h40);
    rd(8'h61, 8'h01);
    rd(8'h62, 8'h01);
    rd(8'h5e, 8'h00);
    rd(8'h70, 8'h00);
    wr(8'h5c, 8'h01);
    wr(8'h5d, 8'h71);
    rd(8'h5d, 8'h71);
    wr(8'h5e, 8'h01);
    rd(8'h5e, 8'h00);
    for (int i = 0; i < 3; i++) begin
      tgt = tl[i];
      tune(8'h01, n0);
      rd(8'h5e, 8'h01);
      rd(8'h59, tgt);
      `CHK("trim_out", tgt[6:0], oscillator_trim_code)
    end
    tune(8'h11, n1);
    `CHK("settle_delta", 112, n1 - n0)
    wr(8'h5c, 8'h01);
    wr(8'h5d, 8'h01);
    wr(8'h5c, 8'h00);
    repeat (20) @(negedge sys_clk);
    `CHK("busy_flag", 1'b0, oscillator_tuning_complete)
    wr(8'h5c, 8'h01);
    rd(8'h5e, 8'h00);
    tune(8'h40, n0);
    `CHK("skip_fast", 1'b1, n0 <= 3)
    wr(8'h59, 8'h2a);
    rd(8'h59, 8'h2a);
    `CHK("trim_write", 7'h2a, oscillator_trim_code)
    for (int i = 0; i < 7; i++) begin
      m = ml[i];
      wr(8'h61, 8'h00);
      repeat (2) @(negedge sys_clk);
      `CHK("div_hold", 2'b11, {cal_logic_reset, div_reset})
      `CHK("fg_held", 1'b0, fg_cal_active)
      wr(8'h62, m);
      wr(8'h61, 8'h01);
      fg = 0;
      pv = 0;
      os = 0;
      repeat (200) begin
        @(negedge sys_clk);
        fg = fg + fg_cal_active;
        pv = pv | cal_values_reset;
        os = os | fg_offset_active;
      end
      `CHK("fg_len", m[0] ? 8'd100 : 8'd0, fg)
      `CHK("val_reset", 1'b1, pv)
      `CHK("fg_offset", m[0] & m[2], os)
      `CHK("bg_cal", m[1], bg_cal_active)
      `CHK("bg_offset", m[1] & m[3], bg_offset_active)
      `CHK("cal_run", 1'b0, cal_logic_reset)
    end
    conclude();
  end
endmodule // pvc_cal_ctrl_test
